// ### inc/ces_regs.vh
// Register offsets, field positions and timing constants of the CAN error block
`ifndef CES_REGS_VH
`define CES_REGS_VH

// Register byte offsets
`define CES_OFF_CTRL     8'h00
`define CES_OFF_STATUS   8'h04
`define CES_OFF_INT_STAT 8'h08
`define CES_OFF_INT_EN   8'h0c
`define CES_OFF_MB_IE    8'h10
`define CES_OFF_TSTAMP   8'h14
`define CES_OFF_MB_BASE  8'h40

// Control register fields
`define CES_CTRL_ILB     0
`define CES_CTRL_ELB     1
`define CES_CTRL_LSN     2
`define CES_CTRL_TXREQ   3

// Interrupt status fields
`define CES_INT_ERR      0
`define CES_INT_PAS      1
`define CES_INT_BOFF     2
`define CES_INT_MB_LSB   8

// Mailbox word selects
`define CES_MB_CFG       2'h0
`define CES_MB_DATA      2'h1
`define CES_MB_TS        2'h2

// Bus states
`define CES_ST_ACTIVE    2'h0
`define CES_ST_PASSIVE   2'h1
`define CES_ST_BUSOFF    2'h2

// Fault confinement figures
`define CES_TEC_INC      9'h008
`define CES_REC_INC      8'h01
`define CES_PASSIVE_LIM  9'h07f
`define CES_BUSOFF_LIM   9'h0ff
`define CES_RUN_LEN      4'hb
`define CES_OCC_NUM      8'h80

// Timing: bit time and clock period in ns, cycles per bit rounded down
`define CES_BIT_NS       2000
`define CES_CLK_NS       100
`define CES_BIT_DIV      (`CES_BIT_NS / `CES_CLK_NS)

`endif

// ### hw/ces_fault.v
// Fault confinement: error counters, bus state and bus-off recovery
`include "ces_regs.vh"

module ces_fault (
  input  wire       sys_clk,
  input  wire       reset_n,
  input  wire       bit_tick,
  input  wire       rx_bit,
  input  wire       tx_err,
  input  wire       rx_err,
  input  wire       tx_ok,
  input  wire       rx_ok,
  output reg  [1:0] state_reg,
  output reg  [8:0] tec_reg,
  output reg  [7:0] rec_reg,
  output reg        ev_pas_reg,
  output reg        ev_boff_reg
);

  reg  [1:0] state_next;   // Next bus state
  reg  [8:0] tec_next;     // Next transmit error count
  reg  [7:0] rec_next;     // Next receive error count
  reg  [3:0] run_reg;      // Consecutive recessive bits seen
  reg  [3:0] run_next;
  reg  [7:0] occ_reg;      // Completed recessive runs in bus off
  reg  [7:0] occ_next;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always @*
  begin
    state_next = state_reg;
    tec_next   = tec_reg;
    rec_next   = rec_reg;
    run_next   = run_reg;
    occ_next   = occ_reg;
    case (state_reg)
      `CES_ST_BUSOFF:
      begin
        // Errors and frames ignored; only recessive runs count
        if (bit_tick)
        begin
          if (!rx_bit)
            run_next = 4'h0; // see R1
          else if (run_reg == `CES_RUN_LEN - 4'h1)
          begin
            run_next = 4'h0;
            if (occ_reg == `CES_OCC_NUM - 8'h01)
            begin
              // Self recovery to error active
              state_next = `CES_ST_ACTIVE; // see R1
              tec_next   = 9'h000;
              rec_next   = 8'h00;
              occ_next   = 8'h00;
            end
            else
              occ_next = occ_reg + 8'h01; // see R1
          end
          else
            run_next = run_reg + 4'h1;
        end
      end
      default:
      begin
        // Transmit counter: up on error, down on success
        if (tx_err)
          tec_next = tec_reg + `CES_TEC_INC; // see R14
        else if (tx_ok && tec_reg != 9'h000)
          tec_next = tec_reg - 9'h001; // see R14
        // Receive counter saturates at its top
        if (rx_err)
          rec_next = (rec_reg == 8'hff) ? rec_reg : rec_reg + `CES_REC_INC;
        else if (rx_ok && rec_reg != 8'h00)
          rec_next = rec_reg - 8'h01; // see R14
        // State from the new counts
        if (tec_next > `CES_BUSOFF_LIM)
        begin
          state_next = `CES_ST_BUSOFF; // see R16
          run_next   = 4'h0;
          occ_next   = 8'h00;
        end
        else if (tec_next > `CES_PASSIVE_LIM ||
                 {1'b0, rec_next} > `CES_PASSIVE_LIM)
          state_next = `CES_ST_PASSIVE; // see R15
        else
          state_next = `CES_ST_ACTIVE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers and entry pulses
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg   <= `CES_ST_ACTIVE;
      tec_reg     <= 9'h000;
      rec_reg     <= 8'h00;
      run_reg     <= 4'h0;
      occ_reg     <= 8'h00;
      ev_pas_reg  <= 1'b0;
      ev_boff_reg <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      tec_reg     <= tec_next;
      rec_reg     <= rec_next;
      run_reg     <= run_next;
      occ_reg     <= occ_next;
      ev_pas_reg  <= (state_reg == `CES_ST_ACTIVE) &&
                     (state_next == `CES_ST_PASSIVE);
      ev_boff_reg <= (state_reg != `CES_ST_BUSOFF) &&
                     (state_next == `CES_ST_BUSOFF);
    end
  end

endmodule

// ### hw/ces_ctrl.v
// CAN error state, test modes, receive mailboxes and register port
//
// How it works
// R1: Bus off recovers after 128 eleven-recessive runs
// R2: Separate enables: error, passive entry, bus off
// R3: Every detected error raises error interrupt
// R4: Internal loopback runs busless, acknowledges itself
// R5: Own frames stored only in loopback modes
// R6: External loopback drives bus, self-acknowledges
// R7: External loopback receives own frames back
// R8: Listen-only never drives dominant level
// R9: Host requests no transmission in listen-only
// R10: Reception copies timestamp into receiving mailbox
// R11: Bus state bits are read-only
// R12: Mailbox interrupt needs enable and mask pass
// R13: Host stops in bus off, reinitializes after
// R14: Error counters count errors and successes
// R15: Passive above threshold, no active flags
// R16: Bus off above 255, no traffic
// R17: Listen-only still stores good frames
`include "ces_regs.vh"

module ces_ctrl #(
  parameter MB_NUM  = 4,
  parameter BIT_DIV = `CES_BIT_DIV
) (
  input  wire        sys_clk,
  input  wire        reset_n,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata_reg,
  input  wire        can_rx,
  output reg         can_tx_reg,
  input  wire        eng_tx_bit,
  input  wire        eng_tx_active,
  input  wire        eng_ack_slot,
  input  wire        eng_err_flag,
  input  wire        eng_tx_err,
  input  wire        eng_rx_err,
  input  wire        eng_tx_ok,
  input  wire        eng_rx_ok,
  input  wire        eng_rx_own,
  input  wire [10:0] eng_rx_id,
  input  wire [31:0] eng_rx_data,
  output reg         eng_rx_bit_reg,
  output reg         eng_tx_start_reg,
  output reg         eng_bus_on_reg,
  output reg         irq_reg
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  reg  [2:0]  mode_reg;        // Loopback and listen-only selects
  reg  [15:0] int_stat_reg;    // Sticky event bits
  reg  [15:0] int_stat_next;
  reg  [15:0] int_set;         // Events of this cycle
  reg  [15:0] int_en_reg;      // Interrupt mask, 1 lets a bit pass
  reg  [7:0]  mb_ie_reg;       // Per-mailbox interrupt enables
  reg  [15:0] ts_reg;          // Timestamp counter
  reg  [15:0] div_cnt_reg;     // Bit time divider
  reg         bit_tick_reg;    // One pulse per bit time
  reg         rx_meta_reg;     // Pin synchroniser, first stage
  reg         rx_sync_reg;     // Pin synchroniser, second stage
  reg  [31:0] rd_next;         // Read data for next cycle
  wire [1:0]  bus_state;       // Error active, passive or bus off
  wire [8:0]  tec;             // Transmit error count
  wire [7:0]  rec;             // Receive error count
  wire        ev_pas;          // Entry into error passive
  wire        ev_boff;         // Entry into bus off
  wire [12*MB_NUM-1:0] cfg_flat;  // Mailbox configs packed
  wire [32*MB_NUM-1:0] data_flat; // Mailbox data packed
  wire [16*MB_NUM-1:0] ts_flat;   // Mailbox stamps packed
  wire [MB_NUM-1:0]    mb_set;    // Mailbox receive events

  ////////////////////////////////////////////////////////////////////////
  // Mode and state decoding
  wire ilb     = mode_reg[`CES_CTRL_ILB];
  wire elb     = mode_reg[`CES_CTRL_ELB];
  wire lsn     = mode_reg[`CES_CTRL_LSN];
  wire loop    = ilb | elb;
  wire boff    = (bus_state == `CES_ST_BUSOFF);
  wire active  = (bus_state == `CES_ST_ACTIVE);
  wire mb_sel  = mb_hit(reg_addr);
  wire [3:0] mb_idx = mb_index(reg_addr);

  // True when the address falls inside the mailbox window
  function mb_hit;
    input [7:0] addr;
    begin
      mb_hit = (addr >= `CES_OFF_MB_BASE) &&
               ({4'h0, mb_index(addr)} < MB_NUM[7:0]);
    end
  endfunction

  // Mailbox number from an address
  function [3:0] mb_index;
    input [7:0] addr;
    reg   [7:0] rel;
    begin
      // Offset into the window first, then one mailbox per 16 bytes
      rel      = addr - `CES_OFF_MB_BASE;
      mb_index = rel[7:4];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bit tick divider and pin synchroniser
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_cnt_reg  <= 16'h0000;
      bit_tick_reg <= 1'b0;
      rx_meta_reg  <= 1'b1;
      rx_sync_reg  <= 1'b1;
    end
    else
    begin
      rx_meta_reg <= can_rx;
      rx_sync_reg <= rx_meta_reg;
      // Wrap after one bit time and pulse the tick
      if (div_cnt_reg == BIT_DIV[15:0] - 16'h0001)
      begin
        div_cnt_reg  <= 16'h0000;
        bit_tick_reg <= 1'b1;
      end
      else
      begin
        div_cnt_reg  <= div_cnt_reg + 16'h0001;
        bit_tick_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fault confinement
  ces_fault u_fault (
    .sys_clk     (sys_clk),
    .reset_n     (reset_n),
    .bit_tick    (bit_tick_reg),
    .rx_bit      (eng_rx_bit_reg),
    .tx_err      (eng_tx_err),
    .rx_err      (eng_rx_err),
    .tx_ok       (eng_tx_ok),
    .rx_ok       (eng_rx_ok),
    .state_reg   (bus_state),
    .tec_reg     (tec),
    .rec_reg     (rec),
    .ev_pas_reg  (ev_pas),
    .ev_boff_reg (ev_boff)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus drive: acknowledge and error flag gating
  // Own-frame ack only in loopback; other frames acked unless listening
  wire ack_drv  = eng_ack_slot & ~lsn &
                  (eng_tx_active ? loop : 1'b1); // see R4, R6, R8
  // Active flags only while error active and not listening
  wire flag_drv = eng_err_flag & ~lsn & active; // see R8, R15
  // Level this node would put on the bus
  wire own_bit  = (boff | lsn) ? 1'b1 :
                  (eng_tx_bit & ~ack_drv & ~flag_drv); // see R8, R16

  ////////////////////////////////////////////////////////////////////////
  // Pin and engine outputs
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      can_tx_reg     <= 1'b1;
      eng_rx_bit_reg <= 1'b1;
      eng_bus_on_reg <= 1'b0;
    end
    else
    begin
      // Internal loopback keeps the pin recessive
      can_tx_reg     <= ilb ? 1'b1 : own_bit; // see R4, R6
      // Internal loopback feeds own bits back; external reads the bus
      if (ilb)
        eng_rx_bit_reg <= own_bit; // see R4
      else
        eng_rx_bit_reg <= rx_sync_reg & ~(elb & ack_drv); // see R6, R7
      eng_bus_on_reg <= ~boff; // see R16
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame delivery into mailboxes
  // Own frames only in loopback, nothing in bus off, listen-only kept
  wire rx_store = eng_rx_ok & ~boff &
                  (~eng_rx_own | loop); // see R5, R7, R16, R17

  genvar g;
  generate
    for (g = 0; g < MB_NUM; g = g + 1)
    begin : mb
      reg  [11:0] cfg_reg;   // Bit 11 receive enable, low bits identifier
      reg  [31:0] data_reg;  // Received data
      reg  [15:0] stamp_reg; // Stamp of last reception
      wire hit = rx_store & cfg_reg[11] &
                 (cfg_reg[10:0] == eng_rx_id);
      wire cfg_wr = reg_wr & mb_sel & (mb_idx == g) &
                    (reg_addr[3:2] == `CES_MB_CFG);

      // Mailbox storage
      always @(posedge sys_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          cfg_reg  <= 12'h000;
          data_reg <= 32'h00000000;
          stamp_reg <= 16'h0000;
        end
        else
        begin
          if (cfg_wr)
            cfg_reg <= reg_wdata[11:0];
          if (hit)
          begin
            data_reg <= eng_rx_data;
            stamp_reg <= ts_reg; // see R10
          end
        end
      end

      assign cfg_flat[12*g +: 12]  = cfg_reg;
      assign data_flat[32*g +: 32] = data_reg;
      assign ts_flat[16*g +: 16]   = stamp_reg;
      assign mb_set[g]             = hit;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Interrupt events and sticky status
  always @*
  begin : int_calc
    integer i;
    i       = 0;
    int_set = 16'h0000;
    int_set[`CES_INT_ERR]  = eng_tx_err | eng_rx_err; // see R3
    int_set[`CES_INT_PAS]  = ev_pas; // see R2
    int_set[`CES_INT_BOFF] = ev_boff; // see R2
    for (i = 0; i < MB_NUM; i = i + 1)
      int_set[`CES_INT_MB_LSB + i] = mb_set[i];
    // Write one clears; a new event wins over the clear
    int_stat_next = int_stat_reg;
    if (reg_wr && reg_addr == `CES_OFF_INT_STAT)
      int_stat_next = int_stat_reg & ~reg_wdata[15:0];
    int_stat_next = int_stat_next | int_set;
  end

  ////////////////////////////////////////////////////////////////////////
  // Software registers, timestamp and interrupt line
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_reg         <= 3'h0;
      int_stat_reg     <= 16'h0000;
      int_en_reg       <= 16'h0000;
      mb_ie_reg        <= 8'h00;
      ts_reg           <= 16'h0000;
      eng_tx_start_reg <= 1'b0;
      irq_reg          <= 1'b0;
    end
    else
    begin
      int_stat_reg <= int_stat_next;
      // Timestamp advances once per bit time
      if (bit_tick_reg)
        ts_reg <= ts_reg + 16'h0001;
      // Control: modes and transmit request
      eng_tx_start_reg <= 1'b0;
      if (reg_wr && reg_addr == `CES_OFF_CTRL)
      begin
        mode_reg <= reg_wdata[2:0];
        // Requests dropped while listening or bus off
        eng_tx_start_reg <= reg_wdata[`CES_CTRL_TXREQ] &
                            ~lsn & ~boff; // see R9, R16
      end
      if (reg_wr && reg_addr == `CES_OFF_INT_EN)
        int_en_reg <= reg_wdata[15:0]; // see R2
      if (reg_wr && reg_addr == `CES_OFF_MB_IE)
        mb_ie_reg <= reg_wdata[7:0];
      // Mailbox bits pass only with their enable and mask set
      irq_reg <= |(int_stat_reg & int_en_reg &
                   {mb_ie_reg, 8'hff}); // see R12
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read multiplexer; status has no write path
  always @*
  begin
    rd_next = 32'h00000000;
    if (mb_sel)
    begin
      case (reg_addr[3:2])
        `CES_MB_CFG:  rd_next = {20'h00000, cfg_flat[12*mb_idx +: 12]};
        `CES_MB_DATA: rd_next = data_flat[32*mb_idx +: 32];
        `CES_MB_TS:   rd_next = {16'h0000, ts_flat[16*mb_idx +: 16]};
        default:      rd_next = 32'h00000000;
      endcase
    end
    else
    begin
      case (reg_addr)
        `CES_OFF_CTRL:     rd_next = {29'h00000000, mode_reg};
        `CES_OFF_STATUS:   rd_next = {7'h00, tec, rec, 6'h00,
                                      bus_state}; // see R11
        `CES_OFF_INT_STAT: rd_next = {16'h0000, int_stat_reg};
        `CES_OFF_INT_EN:   rd_next = {16'h0000, int_en_reg};
        `CES_OFF_MB_IE:    rd_next = {24'h000000, mb_ie_reg};
        `CES_OFF_TSTAMP:   rd_next = {16'h0000, ts_reg};
        default:           rd_next = 32'h00000000;
      endcase
    end
  end

  // Read data register, valid the cycle after the strobe
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata_reg <= 32'h00000000;
    else if (reg_rd)
      reg_rdata_reg <= rd_next;
    else
      reg_rdata_reg <= 32'h00000000;
  end

endmodule

// ### sim/ces_bus_node.sv
// Far CAN node model sharing the bus wire with the block under test
module ces_bus_node (
  input  wire dut_tx,    // Level driven by our node, 0 dominant
  input  wire node_on,   // Far node takes part in traffic
  input  wire node_bit,  // Far node's own bit, 0 dominant
  output wire bus_level  // Resulting wire level seen by all nodes
);
  timeunit 1ns;
  timeprecision 1ns;
  // Wired-AND: dominant wins, an idle wire rests recessive on its pull-up
  assign bus_level = dut_tx & (~node_on | node_bit);
endmodule

// ### sim/ces_ctrl_monitor.sv
// Port checker of the CAN error state and test mode block
`include "ces_regs.vh"

module ces_ctrl_monitor #(
  parameter MB_NUM  = 4,
  parameter BIT_DIV = 20
) (
  input wire        sys_clk,
  input wire        reset_n,
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata_reg,
  input wire        can_rx,
  input wire        can_tx_reg,
  input wire        eng_tx_bit,
  input wire        eng_tx_active,
  input wire        eng_ack_slot,
  input wire        eng_err_flag,
  input wire        eng_tx_err,
  input wire        eng_rx_err,
  input wire        eng_tx_ok,
  input wire        eng_rx_ok,
  input wire        eng_rx_own,
  input wire [10:0] eng_rx_id,
  input wire [31:0] eng_rx_data,
  input wire        eng_rx_bit_reg,
  input wire        eng_tx_start_reg,
  input wire        eng_bus_on_reg,
  input wire        irq_reg
);
  timeunit 1ns;
  timeprecision 1ns;
  reg  [2:0]  mode_reg;  // Loopback and listen bits last written
  reg  [15:0] ie_reg;    // Interrupt enables last written
  reg  [7:0]  mbie_reg;  // Mailbox enables last written
  wire        pass;      // Some enabled path to the interrupt exists
  assign pass = (ie_reg[2:0] != 3'h0) || ((ie_reg[15:8] & mbie_reg) != 8'h0);
  //////////////////////////////////////////////////////////////////////
  // Shadow of the mode and enable registers
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_reg <= 3'h0;
      ie_reg   <= 16'h0;
      mbie_reg <= 8'h0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `CES_OFF_CTRL) mode_reg <= reg_wdata[2:0];
      if (reg_addr == `CES_OFF_INT_EN) ie_reg <= reg_wdata[15:0];
      if (reg_addr == `CES_OFF_MB_IE) mbie_reg <= reg_wdata[7:0];
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Port relations
  default clocking mon_cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_reg == 32'h0)
    else $error("read data not idle");
  err_irq_a: assert property (
    (eng_tx_err || eng_rx_err) && ie_reg[0] && eng_bus_on_reg && !reg_wr
    ##1 !reg_wr |=> irq_reg) else $error("error raised no interrupt");
  mask_gate_a: assert property (
    !pass && !$past(pass) && !$past(pass, 2) |-> !irq_reg)
    else $error("interrupt without enable");
  busoff_quiet_a: assert property (
    !eng_bus_on_reg && !$past(eng_bus_on_reg) |-> can_tx_reg)
    else $error("pin driven while bus off");
  ilb_quiet_a: assert property (
    mode_reg[0] && $past(mode_reg[0]) |-> can_tx_reg)
    else $error("pin driven in internal loopback");
  lsn_quiet_a: assert property (
    mode_reg[2] && $past(mode_reg[2]) |-> can_tx_reg)
    else $error("pin driven in listen-only");
  elb_drive_a: assert property (
    mode_reg == 3'h2 && $past(mode_reg) == 3'h2 && eng_bus_on_reg &&
    !eng_tx_err && eng_tx_active && (eng_ack_slot || !eng_tx_bit)
    |=> !can_tx_reg) else $error("external loopback bit not driven");
  tx_noack_a: assert property (
    mode_reg == 3'h0 && $past(mode_reg) == 3'h0 && eng_tx_active &&
    eng_tx_bit && !eng_err_flag |=> can_tx_reg)
    else $error("own frame acknowledged in normal mode");
  tx_start_a: assert property (
    reg_wr && reg_addr == `CES_OFF_CTRL && reg_wdata[3] && !reg_wdata[2]
    && !mode_reg[2] && eng_bus_on_reg |=> eng_tx_start_reg)
    else $error("transmit request lost");
endmodule

bind ces_ctrl ces_ctrl_monitor #(.MB_NUM(MB_NUM), .BIT_DIV(BIT_DIV))
  ces_ctrl_monitor_inst (.*);

// ### sim/ces_ctrl_tb_top.sv
// Self-checking bench of the CAN error state and test mode block
`include "ces_regs.vh"

module ces_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BD = 2;              // Short bit time keeps recovery brief
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        eng_tx_bit = 1'b1;
  logic        eng_tx_active = 1'b0;
  logic        eng_ack_slot = 1'b0;
  logic        eng_err_flag = 1'b0;
  logic        eng_rx_own = 1'b0;
  logic [10:0] eng_rx_id = 11'h0;
  logic [31:0] eng_rx_data = 32'h0;
  logic [3:0]  ev = 4'h0;             // Ok and error pulses
  logic        node_on = 1'b0;        // Far node active
  logic        node_bit = 1'b1;
  logic        pin_on = 1'b0;         // Random pin traffic and checks
  logic [1:0]  exp_q = 2'h3;          // Expected pin and looped bit
  logic [2:0]  mode = 3'h0;           // Mode the bench has set
  wire         eng_tx_err, eng_rx_err, eng_tx_ok, eng_rx_ok;
  wire         can_rx, can_tx_reg, eng_rx_bit_reg, eng_tx_start_reg;
  wire         eng_bus_on_reg, irq_reg;
  wire  [31:0] reg_rdata_reg;
  integer      seed = 21;
  integer      pseed = 21;
  integer      err_count = 0;
  integer      check_count = 0;
  integer      cyc = 0;
  integer      c0, i;
  logic [31:0] r, d, t0, ed, pr;
  logic [10:0] id;
  logic [7:0]  n;
  assign {eng_rx_ok, eng_tx_ok, eng_rx_err, eng_tx_err} = ev;
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  ces_ctrl #(.MB_NUM(4), .BIT_DIV(BD)) ces_ctrl_inst (.*);
  ces_bus_node ces_bus_node_inst (
    .dut_tx    (can_tx_reg),
    .node_on   (node_on),
    .node_bit  (node_bit),
    .bus_level (can_rx)
  );
  ////////////////////////////////////////////////////////////////////
  // Expected status word from counters and state
  function automatic logic [31:0] st(input [8:0] t, input [7:0] c,
                                     input [1:0] s);
    st = {7'h0, t, c, 6'h0, s};
  endfunction
  // Expected pin level and looped bit for one cycle of engine bits
  function automatic logic [1:0] pin_f(input [2:0] m, input b, a, k, e);
    logic dv;
    dv = b & ~e & ~(k & (~a | m[0] | m[1]));
    pin_f = {m[0] | m[2] | dv, dv};
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task give_verdict;
  begin
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////////////
  // Register port and engine pulse drivers
  task wr(input [7:0] a, input [31:0] v);
  begin
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  end
  endtask
  task rd(input [7:0] a, output [31:0] v);
  begin
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata_reg;
  end
  endtask
  task rchk(input [7:0] a, input [31:0] e);
    logic [31:0] v;
  begin
    rd(a, v);
    chk(v, e);
  end
  endtask
  task frame(input [3:0] v, input [10:0] fid, input [31:0] fd, input own);
  begin
    @(posedge sys_clk);
    ev          <= v;
    eng_rx_id   <= fid;
    eng_rx_data <= fd;
    eng_rx_own  <= own;
    @(posedge sys_clk);
    ev          <= 4'h0;
  end
  endtask
  ////////////////////////////////////////////////////////////////////
  // Random engine bits and far node traffic, with pin expectations
  always @(posedge sys_clk)
  begin
    exp_q <= pin_f(mode, eng_tx_bit, eng_tx_active, eng_ack_slot,
                   eng_err_flag);
    pr = $random(pseed);
    eng_tx_active <= pin_on & pr[0];
    eng_tx_bit    <= ~pin_on | ~pr[0] | pr[1];
    eng_ack_slot  <= pin_on & pr[2] & pr[3];
    eng_err_flag  <= pin_on & (pr[7:4] == 4'h0);
    node_on       <= pin_on;
    node_bit      <= pr[8];
  end
  always @(negedge sys_clk)
    if (pin_on)
    begin
      chk(can_tx_reg, exp_q[1]);
      if (mode == 3'h1) chk(eng_rx_bit_reg, exp_q[0]);
    end
  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    // Falling edge at time zero so the asynchronous reset really fires
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    rchk(`CES_OFF_STATUS, 32'h0);
    wr(`CES_OFF_STATUS, 32'hffffffff);
    rchk(`CES_OFF_STATUS, 32'h0);
    rchk(8'h3c, 32'h0);
    // Each single receive error interrupts
    wr(`CES_OFF_INT_EN, 32'h1);
    r = $random(seed);
    n = 8'h2 + {6'h0, r[1:0]};
    for (i = 0; i < n; i++)
    begin
      frame(4'h2, 11'h0, 32'h0, 1'b0);
      rchk(`CES_OFF_INT_STAT, 32'h1);
      chk(irq_reg, 1'b1);
      wr(`CES_OFF_INT_STAT, 32'h1);
    end
    rchk(`CES_OFF_STATUS, st(9'h0, n, 2'h0));
    chk(irq_reg, 1'b0);
    frame(4'hc, 11'h0, 32'h0, 1'b0);
    rchk(`CES_OFF_STATUS, st(9'h0, n - 8'h1, 2'h0));
    // Passive threshold, then bus off threshold
    wr(`CES_OFF_INT_EN, 32'h2);
    repeat (15) frame(4'h1, 11'h0, 32'h0, 1'b0);
    rchk(`CES_OFF_STATUS, st(9'h078, n - 8'h1, 2'h0));
    frame(4'h1, 11'h0, 32'h0, 1'b0);
    rchk(`CES_OFF_STATUS, st(9'h080, n - 8'h1, 2'h1));
    rchk(`CES_OFF_INT_STAT, 32'h3);
    chk(irq_reg, 1'b1);
    wr(`CES_OFF_INT_STAT, 32'h2);
    rchk(`CES_OFF_INT_STAT, 32'h1);
    chk(irq_reg, 1'b0);
    wr(`CES_OFF_INT_EN, 32'h4);
    repeat (15) frame(4'h1, 11'h0, 32'h0, 1'b0);
    rchk(`CES_OFF_STATUS, st(9'h0f8, n - 8'h1, 2'h1));
    frame(4'h1, 11'h0, 32'h0, 1'b0);
    c0 = cyc;
    frame(4'h1, 11'h0, 32'h0, 1'b0);
    chk(eng_bus_on_reg, 1'b0);
    rchk(`CES_OFF_STATUS, st(9'h100, n - 8'h1, 2'h2));
    rchk(`CES_OFF_INT_STAT, 32'h5);
    chk(irq_reg, 1'b1);
    // Idle bus: automatic return to error active
    while (eng_bus_on_reg !== 1'b1 && cyc - c0 < 1408 * BD + 40)
      @(posedge sys_clk);
    if (eng_bus_on_reg !== 1'b1)
    begin
      err_count = err_count + 1;
      give_verdict;
    end
    c0 = cyc - c0 - 1408 * BD;
    chk(c0 >= -4 && c0 <= 12, 1'b1);
    rchk(`CES_OFF_STATUS, 32'h0);
    wr(`CES_OFF_INT_STAT, 32'hffff);
    // Mailbox interrupt path needs both enables
    r = $random(seed);
    id = r[10:0];
    wr(`CES_OFF_MB_BASE, {20'h0, 1'b1, id});
    wr(`CES_OFF_MB_BASE + 8'h10, {20'h0, 1'b1, ~id});
    wr(`CES_OFF_INT_EN, 32'h300);
    frame(4'h8, ~id, r, 1'b0);
    rchk(`CES_OFF_INT_STAT, 32'h200);
    chk(irq_reg, 1'b0);
    wr(`CES_OFF_MB_IE, 32'h2);
    rchk(`CES_OFF_INT_STAT, 32'h200);
    chk(irq_reg, 1'b1);
    wr(`CES_OFF_INT_STAT, 32'h200);
    // Own and foreign frames in every mode, with timestamps
    ed = 32'h0;
    for (i = 0; i < 8; i++)
    begin
      mode = (i[1:0] == 2'h3) ? 3'h4 : {1'b0, i[1:0]};
      wr(`CES_OFF_CTRL, {29'h0, mode});
      rd(`CES_OFF_TSTAMP, t0);
      d = $random(seed);
      frame(4'h8, id, d, i[2]);
      if (!i[2] || mode[1:0] != 2'h0) ed = d;
      rchk(`CES_OFF_MB_BASE + 8'h4, ed);
      rd(`CES_OFF_MB_BASE + 8'h8, r);
      if (ed === d) chk(r[15:0] - t0[15:0] <= 16'h2, 1'b1);
    end
    // Random pin traffic in each mode, tx request outside listen-only
    for (i = 0; i < 4; i++)
    begin
      mode = (i == 3) ? 3'h4 : i[2:0];
      wr(`CES_OFF_CTRL, {28'h0, mode != 3'h4, mode});
      @(posedge sys_clk);
      pin_on <= 1'b1;
      repeat (80) @(posedge sys_clk);
      pin_on <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    give_verdict;
  end
endmodule
